// file: posmux_defines.vh
// register map, field layout and reset values of the pin output source mux
`ifndef POSMUX_DEFINES_VH
`define POSMUX_DEFINES_VH

`define POSMUX_ADDR_W          4
`define POSMUX_OFF_CTRL        4'h0
`define POSMUX_OFF_STATUS      4'h4
`define POSMUX_OFF_PORT_EN     4'h8
`define POSMUX_OFF_TX_MAP      4'hC

`define POSMUX_CTRL_RESET      8'h00
`define POSMUX_PORT_EN_RESET   4'hF
`define POSMUX_TX_MAP_RESET    8'hFF

`define POSMUX_SEL_HI          7
`define POSMUX_SEL_LO          5
`define POSMUX_SRC_HI          4
`define POSMUX_SRC_LO          2
`define POSMUX_VAL_BIT         1
`define POSMUX_EN_BIT          0

`define POSMUX_SRC_DEV         3'h4
`define POSMUX_SRC_RSVD        3'h5
`define POSMUX_SRC_TX0         3'h6
`define POSMUX_SRC_TX1         3'h7

`define POSMUX_SEL_LOCK        3'h4
`define POSMUX_SEL_PASS        3'h5
`define POSMUX_SEL_FV          3'h6
`define POSMUX_SEL_LV          3'h7

`define POSMUX_DSEL_VAL        3'h0
`define POSMUX_DSEL_LOCK_OR    3'h1
`define POSMUX_DSEL_PASS_AND_A 3'h2
`define POSMUX_DSEL_PASS_AND_B 3'h3
`define POSMUX_DSEL_FSYNC      3'h4

`define POSMUX_TSEL_PASS_AND   3'h0
`define POSMUX_TSEL_PASS_OR    3'h1
`define POSMUX_TSEL_FV         3'h2
`define POSMUX_TSEL_LV         3'h3
`define POSMUX_TSEL_SYNC       3'h4
`define POSMUX_TSEL_IRQ        3'h5

`endif

// file: posmux_pin_load.sv
// pull-down load on the general purpose pin
`timescale 1ns/1ps
module posmux_pin_load (
    input  wire pin_i,
    input  wire oe_i,
    output wire level_o
);
    // a released pin falls to the pull-down, never keeps its last value
    assign level_o = oe_i ? pin_i : 1'b0;
endmodule // posmux_pin_load

// file: posmux_properties.sv
// checker for the pin 5 output source mux
`timescale 1ns/1ps
module posmux_properties (
    input wire        clk_i,
    input wire        rst_i,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [3:0]  wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0]  wb_sel_i,
    input wire        wb_ack_o,
    input wire        wb_err_o,
    input wire [15:0] remote_pin_i,
    input wire        frame_sync_pulse_i,
    input wire        general_pin_5_o,
    input wire        general_pin_5_oe_o
);
    reg  [7:0] c_q;
    wire       take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    // shadow of the control byte, follows taken writes only
    always @(posedge clk_i) begin
        if (rst_i)
            c_q <= 8'h00;
        else if (take && wb_we_i && wb_adr_i == 4'h0 && wb_sel_i[0])
            c_q <= wb_dat_i[7:0];
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////////////
    property p_ack; take |=> wb_ack_o || wb_err_o; endproperty
    a_ack: assert property (p_ack) else $error("bus request not answered");
    property p_drop; wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o; endproperty
    a_drop: assert property (p_drop) else $error("bus answer longer than one cycle");
    property p_err; take && wb_adr_i[1:0] != 2'h0 |=> wb_err_o; endproperty
    a_err: assert property (p_err) else $error("unmapped access not refused");
    property p_oe; general_pin_5_oe_o == $past(c_q[0] && c_q[4:2] != 3'h5); endproperty
    a_oe: assert property (p_oe) else $error("output enable wrong");
    property p_off; !general_pin_5_oe_o |-> !general_pin_5_o; endproperty
    a_off: assert property (p_off) else $error("pin driven while disabled");
    property p_val; $past(c_q[7:2]) == 6'h04 |-> general_pin_5_o == $past(c_q[1] && c_q[0]); endproperty
    a_val: assert property (p_val) else $error("register value not on pin");
    property p_fs; $past(c_q) == 8'h91 |-> general_pin_5_o == $past(frame_sync_pulse_i); endproperty
    a_fs: assert property (p_fs) else $error("frame sync not on pin");
    property p_rx;
        $past(c_q[0]) && !$past(c_q[7]) && !$past(c_q[4])
            |-> general_pin_5_o == $past(remote_pin_i[{c_q[3:2], c_q[6:5]}]);
    endproperty
    a_rx: assert property (p_rx) else $error("remote pin not routed");
endmodule // posmux_properties

bind posmux_top posmux_properties i_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .remote_pin_i(remote_pin_i),
    .frame_sync_pulse_i(frame_sync_pulse_i), .general_pin_5_o(general_pin_5_o),
    .general_pin_5_oe_o(general_pin_5_oe_o));

// file: posmux_rx_select.v
// per-receive-port signal select
`timescale 1ns/1ps
`include "posmux_defines.vh"

module posmux_rx_select (
    input  wire [3:0] remote_pins_i,
    input  wire       lock_i,
    input  wire       pass_i,
    input  wire       frame_valid_i,
    input  wire       line_valid_i,
    input  wire [2:0] pin_output_select_i,
    output reg        bit_o
);

    always @* begin
        case (pin_output_select_i)
            3'h0, 3'h1, 3'h2, 3'h3: bit_o = remote_pins_i[pin_output_select_i[1:0]];
            `POSMUX_SEL_LOCK:      bit_o = lock_i;
            `POSMUX_SEL_PASS:      bit_o = pass_i;
            `POSMUX_SEL_FV:        bit_o = frame_valid_i;
            `POSMUX_SEL_LV:        bit_o = line_valid_i;
            default:               bit_o = 1'b0;
        endcase
    end

endmodule // posmux_rx_select

// file: posmux_top.v
// pin 5 output source mux with classic wishbone register slave
`timescale 1ns/1ps
`include "posmux_defines.vh"

// Notes on behaviour
// - source bits 4:2 pick rx port 0-3, device status, or tx port 0/1.
// - source code 101 is reserved and drives nothing valid.
// - rx source, select 000-011 routes that port's remote pin 0-3.
// - rx source, select 100 gives port lock, 101 gives port pass.
// - rx source, select 110 gives frame valid, 111 gives line valid.
// - device status, select 000 drives the register's output value bit.
// - device status, select 001 drives OR of locks of enabled rx ports.
// - device status, selects 010 and 011 drive AND of enabled ports' pass.
// - device status, select 100 drives frame sync; 101-111 reserved.
// - tx source, select 000 gives AND of pass of feeding rx ports.
// - tx source, select 001 gives OR of pass of feeding rx ports.
// - tx source, select 010 high during frame, 011 during line.
// - tx source, select 100 shows multi-port data synchronised.
// - tx source, select 101 gives tx port interrupt; 110-111 reserved.
// - bit 1 holds the level driven when register value is selected.
// - bit 0 gates the output driver, 0 off, 1 on.
module posmux_top (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [31:0] wb_dat_i,
    input  wire [3:0]  wb_sel_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output reg         wb_err_o,
    input  wire [15:0] remote_pin_i,
    input  wire [3:0]  rx_lock_i,
    input  wire [3:0]  rx_pass_i,
    input  wire [3:0]  rx_frame_valid_i,
    input  wire [3:0]  rx_line_valid_i,
    input  wire        frame_sync_pulse_i,
    input  wire [1:0]  tx_frame_active_i,
    input  wire [1:0]  tx_line_active_i,
    input  wire [1:0]  tx_synced_i,
    input  wire [1:0]  tx_irq_i,
    output reg         general_pin_5_o,
    output reg         general_pin_5_oe_o
);

    ////////////////////////////////////////////////////////////////////////
    // registers

    reg  [7:0] ctrl_q;
    reg  [3:0] port_en_q;
    reg  [7:0] tx_map_q;

    wire [2:0] pin_output_select = ctrl_q[`POSMUX_SEL_HI:`POSMUX_SEL_LO];
    wire [2:0] pin_output_source = ctrl_q[`POSMUX_SRC_HI:`POSMUX_SRC_LO];
    wire       pin_output_value  = ctrl_q[`POSMUX_VAL_BIT];
    wire       pin_output_enable = ctrl_q[`POSMUX_EN_BIT];

    function is_mapped;
        input [3:0] adr;
        begin
            is_mapped = (adr == `POSMUX_OFF_CTRL) || (adr == `POSMUX_OFF_STATUS) ||
                        (adr == `POSMUX_OFF_PORT_EN) || (adr == `POSMUX_OFF_TX_MAP);
        end
    endfunction

    // one wait state: ack registered, dropped the cycle after it was given
    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    wire wr  = req & wb_we_i & wb_sel_i[0] & is_mapped(wb_adr_i);

    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q    <= `POSMUX_CTRL_RESET;
            port_en_q <= `POSMUX_PORT_EN_RESET;
            tx_map_q  <= `POSMUX_TX_MAP_RESET;
        end else if (wr) begin
            case (wb_adr_i)
                `POSMUX_OFF_CTRL:    ctrl_q    <= wb_dat_i[7:0];
                `POSMUX_OFF_PORT_EN: port_en_q <= wb_dat_i[3:0];
                `POSMUX_OFF_TX_MAP:  tx_map_q  <= wb_dat_i[7:0];
                default:             ctrl_q    <= ctrl_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // source selection

    wire [3:0] rx_bit;
    wire [1:0] tx_bit;

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_rx
            posmux_rx_select u_rx (
                .remote_pins_i       (remote_pin_i[4*g+3:4*g]),
                .lock_i              (rx_lock_i[g]),
                .pass_i              (rx_pass_i[g]),
                .frame_valid_i       (rx_frame_valid_i[g]),
                .line_valid_i        (rx_line_valid_i[g]),
                .pin_output_select_i (pin_output_select),
                .bit_o               (rx_bit[g])
            );
        end
        for (g = 0; g < 2; g = g + 1) begin : g_tx
            posmux_tx_select u_tx (
                .rx_pass_i           (rx_pass_i),
                .feed_map_i          (tx_map_q[4*g+3:4*g]),
                .frame_active_i      (tx_frame_active_i[g]),
                .line_active_i       (tx_line_active_i[g]),
                .synced_i            (tx_synced_i[g]),
                .irq_i               (tx_irq_i[g]),
                .pin_output_select_i (pin_output_select),
                .bit_o               (tx_bit[g])
            );
        end
    endgenerate

    // no port enabled: and reads low rather than vacuously high
    wire lock_or  = |(rx_lock_i & port_en_q);
    wire pass_and = (|port_en_q) & (&(rx_pass_i | ~port_en_q));

    reg dev_bit;
    always @* begin
        case (pin_output_select)
            `POSMUX_DSEL_VAL:        dev_bit = pin_output_value;
            `POSMUX_DSEL_LOCK_OR:    dev_bit = lock_or;
            `POSMUX_DSEL_PASS_AND_A: dev_bit = pass_and;
            `POSMUX_DSEL_PASS_AND_B: dev_bit = pass_and;
            `POSMUX_DSEL_FSYNC:      dev_bit = frame_sync_pulse_i;
            default:                 dev_bit = 1'b0;
        endcase
    end

    reg src_bit;
    reg src_ok;
    always @* begin
        src_ok = 1'b1;
        case (pin_output_source)
            3'h0, 3'h1, 3'h2, 3'h3: src_bit = rx_bit[pin_output_source[1:0]];
            `POSMUX_SRC_DEV:       src_bit = dev_bit;
            `POSMUX_SRC_TX0:       src_bit = tx_bit[0];
            `POSMUX_SRC_TX1:       src_bit = tx_bit[1];
            default: begin
                src_bit = 1'b0;
                src_ok  = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // pin and bus outputs, one register stage

    always @(posedge clk_i) begin
        if (rst_i) begin
            general_pin_5_o    <= 1'b0;
            general_pin_5_oe_o <= 1'b0;
        end else begin
            // reserved source: driver stays off rather than drive junk
            general_pin_5_oe_o <= pin_output_enable & src_ok;
            general_pin_5_o    <= pin_output_enable & src_ok & src_bit;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req & is_mapped(wb_adr_i);
            wb_err_o <= req & ~is_mapped(wb_adr_i);
            wb_dat_o <= 32'h0000_0000;
            if (req & ~wb_we_i) begin
                case (wb_adr_i)
                    `POSMUX_OFF_CTRL:    wb_dat_o <= {24'h00_0000, ctrl_q};
                    `POSMUX_OFF_STATUS:  wb_dat_o <= {29'h0000_0000, src_ok, general_pin_5_oe_o,
                                                      general_pin_5_o};
                    `POSMUX_OFF_PORT_EN: wb_dat_o <= {28'h000_0000, port_en_q};
                    `POSMUX_OFF_TX_MAP:  wb_dat_o <= {24'h00_0000, tx_map_q};
                    default:             wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule // posmux_top

// file: posmux_tx_select.v
// per-transmit-port signal select
`timescale 1ns/1ps
`include "posmux_defines.vh"

module posmux_tx_select (
    input  wire [3:0] rx_pass_i,
    input  wire [3:0] feed_map_i,
    input  wire       frame_active_i,
    input  wire       line_active_i,
    input  wire       synced_i,
    input  wire       irq_i,
    input  wire [2:0] pin_output_select_i,
    output reg        bit_o
);

    // no feeding port: and reads low, so an unmapped port never looks healthy
    wire pass_and = (|feed_map_i) & (&(rx_pass_i | ~feed_map_i));
    wire pass_or  = |(rx_pass_i & feed_map_i);

    always @* begin
        case (pin_output_select_i)
            `POSMUX_TSEL_PASS_AND: bit_o = pass_and;
            `POSMUX_TSEL_PASS_OR:  bit_o = pass_or;
            `POSMUX_TSEL_FV:       bit_o = frame_active_i;
            `POSMUX_TSEL_LV:       bit_o = line_active_i;
            `POSMUX_TSEL_SYNC:     bit_o = synced_i;
            `POSMUX_TSEL_IRQ:      bit_o = irq_i;
            default:               bit_o = 1'b0;
        endcase
    end

endmodule // posmux_tx_select

// file: test_pin5_output_source_mux.sv
// testbench for the pin 5 output source mux
`timescale 1ns/1ps
module test_pin5_output_source_mux;
    reg         clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, e_f;
    reg  [3:0]  adr = 0, sel = 0, e = 4'hF;
    reg  [7:0]  m = 8'hFF;
    reg  [31:0] dat = 0, r;
    reg  [40:0] v = 0;
    wire [31:0] rd;
    wire        ack, err, pin, oe, lvl;
    integer     fails = 0, checked = 0, i, k;
    posmux_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(rd), .wb_ack_o(ack), .wb_err_o(err),
        .remote_pin_i(v[40:25]), .rx_lock_i(v[24:21]), .rx_pass_i(v[20:17]), .rx_frame_valid_i(v[16:13]),
        .rx_line_valid_i(v[12:9]), .frame_sync_pulse_i(v[8]), .tx_frame_active_i(v[7:6]),
        .tx_line_active_i(v[5:4]), .tx_synced_i(v[3:2]), .tx_irq_i(v[1:0]),
        .general_pin_5_o(pin), .general_pin_5_oe_o(oe));
    posmux_pin_load i_load (.pin_i(pin), .oe_i(oe), .level_o(lvl));
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // expected pin level for a control byte and the present inputs
    function f(input [7:0] c);
        reg [3:0] mk;
        begin
            mk = c[2] ? m[7:4] : m[3:0];
            f = 0;
            if (!c[0] || c[4:2] == 3'h5) f = 0;
            else if (!c[4]) f = c[7] ? v[37 - 4 * c[7:5] + c[3:2]] : v[25 + 4 * c[3:2] + c[6:5]];
            else if (c[3:2] == 2'h0) case (c[7:5])
                3'h0: f = c[1];
                3'h1: f = |(v[24:21] & e);
                3'h2, 3'h3: f = (e != 0) && &(v[20:17] | ~e);
                3'h4: f = v[8];
            endcase
            else case (c[7:5])
                3'h0: f = (mk != 0) && &(v[20:17] | ~mk);
                3'h1: f = |(v[20:17] & mk);
                3'h2: f = v[6 + c[2]];
                3'h3: f = v[4 + c[2]];
                3'h4: f = v[2 + c[2]];
                3'h5: f = v[c[2]];
            endcase
        end
    endfunction
    task chk(input string n, input [31:0] x, input [31:0] g);
        begin
            checked = checked + 1;
            if (g !== x) begin
                fails = fails + 1;
                $display("unexpected %s exp %h got %h", n, x, g);
            end
        end
    endtask
    task wb(input w, input [3:0] a, input [31:0] d, input [3:0] s);
        integer n;
        begin
            @(posedge clk_i);
            cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; sel <= s;
            n = 0;
            // no local limit: only the watchdog ends a wait for the answer
            do begin
                @(posedge clk_i);
                n = n + 1;
            end while (ack !== 1 && err !== 1);
            r = rd;
            e_f = err;
            cyc <= 0;
            stb <= 0;
            chk("bus latency", 2, n);
        end
    endtask
    task t_regs;
        begin
            wb(0, 4'h0, 0, 4'hF); chk("ctrl reset", 32'h0, r);
            wb(0, 4'h8, 0, 4'hF); chk("port enable reset", 32'hF, r);
            wb(0, 4'hC, 0, 4'hF); chk("feed map reset", 32'hFF, r);
            wb(1, 4'h0, 32'hFF, 4'h0); wb(0, 4'h0, 0, 4'hF); chk("ctrl masked write", 32'h0, r);
            wb(1, 4'h0, 32'hFE, 4'h1); wb(0, 4'h0, 0, 4'hF); chk("ctrl readback", 32'hFE, r);
            wb(0, 4'h4, 0, 4'hF); chk("status disabled", 32'h4, r);
            wb(0, 4'h6, 0, 4'hF); chk("unmapped err", 1, e_f); chk("unmapped data", 32'h0, r);
            $display("test registers done");
        end
    endtask
    task t_mux;
        begin
            for (k = 0; k < 4; k = k + 1) begin
                if (k == 2) begin
                    wb(1, 4'h8, 32'h5, 4'h1); e = 4'h5;
                    wb(1, 4'hC, 32'h3C, 4'h1); m = 8'h3C;
                    wb(0, 4'h8, 0, 4'hF); chk("port enable readback", 32'h5, r);
                    wb(0, 4'hC, 0, 4'hF); chk("feed map readback", 32'h3C, r);
                end
                @(posedge clk_i);
                v <= k[1] ? (k[0] ? 41'h0AA_AAAA_AAAA : 41'h155_5555_5555) : (k[0] ? ~41'h0 : 41'h0);
                for (i = 0; i < 256; i = i + 1) begin
                    wb(1, 4'h0, i, 4'h1);
                    @(posedge clk_i);
                    #1;
                    chk("pin level", f(i), lvl);
                    chk("pin enable", i[0] && i[4:2] != 3'h5, oe);
                end
            end
            // last control byte 0xFF: valid source, enabled, reserved select drives low
            wb(0, 4'h4, 0, 4'hF); chk("status enabled", 32'h6, r);
            $display("test source mux done");
        end
    endtask
    task finish_test;
        begin
            $display("counts fails %0d checked %0d", fails, checked);
            if (fails == 0 && checked > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    initial begin
        #800000;
        fails = fails + 1;
        finish_test;
    end
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        #1;
        chk("pin after reset", 0, {pin, oe});
        t_regs;
        t_mux;
        finish_test;
    end
endmodule // test_pin5_output_source_mux
